// [rtl/flash_guard_core_end.sv]
// Core end: turns user requests into register and external-move cycles
`timescale 1ns/10ps
module flash_guard_core_end
  import flash_guard_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  flash_guard_if.core      bus,
  input  wire logic        req_sfr_wr,
  input  wire logic        req_sfr_rd,
  input  wire logic [7:0]  req_sfr_addr,
  input  wire logic [7:0]  req_sfr_wdata,
  input  wire logic        req_xm_wr,
  input  wire logic        req_xm_rd,
  input  wire logic        req_xm_short,
  input  wire logic [15:0] req_xm_addr,
  input  wire logic [7:0]  req_xm_wdata,
  input  wire logic        req_code_rd,
  output logic [7:0]       rsp_sfr_rdata,
  output logic [7:0]       rsp_xm_rdata,
  output logic             rsp_xm_valid,
  output logic             rsp_busy
);
  // Cycles are issued only when the device is not stalling
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      bus.sfr_wr    <= 1'b0;
      bus.sfr_rd    <= 1'b0;
      bus.sfr_addr  <= 8'h00;
      bus.sfr_wdata <= 8'h00;
      bus.xm_wr     <= 1'b0;
      bus.xm_rd     <= 1'b0;
      bus.xm_short  <= 1'b0;
      bus.xm_addr   <= 16'h0000;
      bus.xm_wdata  <= 8'h00;
      bus.code_rd   <= 1'b0;
    end else begin
      bus.sfr_wr    <= req_sfr_wr && !bus.cpu_stall;
      bus.sfr_rd    <= req_sfr_rd && !bus.cpu_stall;
      bus.sfr_addr  <= req_sfr_addr;
      bus.sfr_wdata <= req_sfr_wdata;
      bus.xm_wr     <= req_xm_wr && !bus.cpu_stall;
      bus.xm_rd     <= req_xm_rd && !bus.cpu_stall;
      bus.xm_short  <= req_xm_short;
      bus.xm_addr   <= req_xm_addr;
      bus.xm_wdata  <= req_xm_wdata;
      bus.code_rd   <= req_code_rd && !bus.cpu_stall;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rsp_sfr_rdata <= 8'h00;
      rsp_xm_rdata  <= 8'h00;
      rsp_xm_valid  <= 1'b0;
      rsp_busy      <= 1'b0;
    end else begin
      rsp_sfr_rdata <= bus.sfr_rdata;
      rsp_xm_rdata  <= bus.xm_rdata;
      rsp_xm_valid  <= bus.xm_rvalid;
      rsp_busy      <= bus.cpu_stall || bus.irq_hold;
    end
  end
endmodule : flash_guard_core_end

// [rtl/flash_guard_if.sv]
// Core-to-guard special-register and external-move interface
`timescale 1ns/10ps
interface flash_guard_if;
  logic       sfr_wr;
  logic       sfr_rd;
  logic [7:0] sfr_addr;
  logic [7:0] sfr_wdata;
  logic [7:0] sfr_rdata;
  logic       xm_wr;
  logic       xm_rd;
  logic       xm_short;
  logic [15:0] xm_addr;
  logic [7:0] xm_wdata;
  logic [7:0] xm_rdata;
  logic       xm_rvalid;
  logic       cpu_stall;
  logic       irq_hold;
  logic       code_rd;
  logic       sense_pulse;
  modport device (
    input  sfr_wr, sfr_rd, sfr_addr, sfr_wdata, xm_wr, xm_rd, xm_short, xm_addr,
           xm_wdata, code_rd,
    output sfr_rdata, xm_rdata, xm_rvalid, cpu_stall, irq_hold, sense_pulse
  );
  modport core (
    output sfr_wr, sfr_rd, sfr_addr, sfr_wdata, xm_wr, xm_rd, xm_short, xm_addr,
           xm_wdata, code_rd,
    input  sfr_rdata, xm_rdata, xm_rvalid, cpu_stall, irq_hold, sense_pulse
  );
endinterface : flash_guard_if

// [rtl/flash_guard_pkg.sv]
// Shared constants and types for the flash write/erase guard
package flash_guard_pkg;
  localparam logic [7:0] PSC_ADDR     = 8'h8f;
  localparam logic [7:0] SCALE_ADDR   = 8'hb6;
  localparam logic [7:0] KEY_ADDR     = 8'hb7;
  localparam logic [7:0] XPAGE_ADDR   = 8'haa;
  localparam logic [7:0] PSC_RESET    = 8'h00;
  localparam logic [7:0] SCALE_RESET  = 8'h80;
  localparam logic [7:0] XPAGE_RESET  = 8'h00;
  localparam int         WEN_POS      = 0;
  localparam int         EEN_POS      = 1;
  localparam int         ONESHOT_POS  = 7;
  localparam int         PAGE_SEL_POS = 0;
  localparam logic [7:0] KEY_FIRST    = 8'ha5;
  localparam logic [7:0] KEY_SECOND   = 8'hf1;
  localparam int         XDATA_BYTES  = 512;
  localparam int         XDATA_AW     = 9;
  localparam int         FLASH_AW     = 16;
  localparam int         PAGE_AW      = 9;
  localparam int         CLK_MHZ      = 100;
  localparam int         WRITE_US     = 40;
  localparam int         ERASE_MS     = 10;
  localparam int         WRITE_CYCLES = WRITE_US * CLK_MHZ;
  localparam int         ERASE_CYCLES = ERASE_MS * 1000 * CLK_MHZ;
  typedef enum logic [1:0] {
    KEY_LOCKED   = 2'b00,
    KEY_HALF     = 2'b01,
    KEY_OPEN     = 2'b10,
    KEY_DISABLED = 2'b11
  } key_state_t;
endpackage : flash_guard_pkg

// [rtl/flash_write_erase_guard.sv]
// Device end: flash write/erase guard, key lock and on-chip xdata RAM
// Summary of operation
// - Write enable routes external-move writes to flash.
// - Both enables: write erases addressed page.
// - Control register upper six bits read zero.
// - Keys 0xA5 then 0xF1 unlock flash.
// - Starting an operation relocks the key state.
// - Bad key or locked attempt disables until reset.
// - Key register reads lock state, two bits.
// - One-shot bit selects brief sense pulse.
// - Scale low seven bits read zero.
// - Interrupts held pending during flash operation.
// - Otherwise external moves hit 512-byte RAM.
// - Short moves take address bit 8 from page.
// - Long pointer ignores upper seven address bits.
// - Software erases before programming a byte.
// - Software disables interrupts around write enable.
// - External-move reads always hit data RAM.
// - Page register keeps only its low bit.
`timescale 1ns/10ps
module flash_write_erase_guard
  import flash_guard_pkg::*;
#(
  parameter int WRITE_TICKS = WRITE_CYCLES,
  parameter int ERASE_TICKS = ERASE_CYCLES
) (
  input  wire logic         clk_sys,
  input  wire logic         arst_n,
  flash_guard_if.device     bus,
  output logic              flash_prog,
  output logic              flash_erase,
  output logic [15:0]       flash_addr,
  output logic [7:0]        flash_wdata
);
  logic [7:0]  ram_mem [XDATA_BYTES];
  logic        wen_ff;
  logic        een_ff;
  logic        oneshot_ff;
  logic        page_sel_ff;
  key_state_t  key_ff;
  key_state_t  nxt_key;
  logic        busy_ff;
  logic [31:0] cnt_ff;
  logic [7:0]  rdata_ff;
  logic [7:0]  xrdata_ff;
  logic        xrvalid_ff;
  logic        sense_ff;
  logic [XDATA_AW-1:0] ram_idx;
  logic        sfr_we;
  logic        fl_req;
  logic        fl_ok;

  assign sfr_we = bus.sfr_wr && !busy_ff;
  assign fl_req = bus.xm_wr && wen_ff && !busy_ff;
  assign fl_ok  = fl_req && (key_ff == KEY_OPEN);

  // Short moves use page bit, long ones drop bits 15:9
  always_comb begin
    if (bus.xm_short) begin
      ram_idx = {page_sel_ff, bus.xm_addr[7:0]};
    end else begin
      ram_idx = bus.xm_addr[XDATA_AW-1:0];
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wen_ff   <= 1'b0;
      een_ff   <= 1'b0;
      oneshot_ff  <= SCALE_RESET[ONESHOT_POS];
      page_sel_ff <= XPAGE_RESET[PAGE_SEL_POS];
    end else if (sfr_we) begin
      if (bus.sfr_addr == PSC_ADDR) begin
        wen_ff <= bus.sfr_wdata[WEN_POS];
        een_ff <= bus.sfr_wdata[EEN_POS];
      end
      if (bus.sfr_addr == SCALE_ADDR) begin
        oneshot_ff <= bus.sfr_wdata[ONESHOT_POS];
      end
      if (bus.sfr_addr == XPAGE_ADDR) begin
        page_sel_ff <= bus.sfr_wdata[PAGE_SEL_POS];
      end
    end
  end

  // Key state machine; disabled state only leaves on reset
  always_comb begin
    nxt_key = key_ff;
    case (key_ff)
      KEY_LOCKED: begin
        if (sfr_we && bus.sfr_addr == KEY_ADDR) begin
          nxt_key = (bus.sfr_wdata == KEY_FIRST) ? KEY_HALF : KEY_DISABLED;
        end else if (fl_req) begin
          nxt_key = KEY_DISABLED;
        end
      end
      KEY_HALF: begin
        if (sfr_we && bus.sfr_addr == KEY_ADDR) begin
          nxt_key = (bus.sfr_wdata == KEY_SECOND) ? KEY_OPEN : KEY_DISABLED;
        end else if (fl_req) begin
          nxt_key = KEY_DISABLED;
        end
      end
      KEY_OPEN: begin
        if (fl_ok) begin
          nxt_key = KEY_LOCKED;
        end else if (sfr_we && bus.sfr_addr == KEY_ADDR) begin
          nxt_key = KEY_DISABLED;
        end
      end
      KEY_DISABLED: nxt_key = KEY_DISABLED;
      default:      nxt_key = KEY_DISABLED;
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      key_ff <= KEY_LOCKED;
    end else begin
      key_ff <= nxt_key;
    end
  end

  // Operation timer; the key relocks when the request is taken
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      busy_ff     <= 1'b0;
      cnt_ff      <= 32'h0000_0000;
      flash_prog  <= 1'b0;
      flash_erase <= 1'b0;
      flash_addr  <= 16'h0000;
      flash_wdata <= 8'h00;
    end else if (fl_ok) begin
      busy_ff     <= 1'b1;
      flash_prog  <= !een_ff;
      flash_erase <= een_ff;
      flash_addr  <= een_ff ? {bus.xm_addr[15:PAGE_AW], {PAGE_AW{1'b0}}} : bus.xm_addr;
      flash_wdata <= een_ff ? 8'hff : bus.xm_wdata;
      cnt_ff      <= een_ff ? 32'(ERASE_TICKS - 1) : 32'(WRITE_TICKS - 1);
    end else if (busy_ff) begin
      if (cnt_ff == 32'h0000_0000) begin
        busy_ff     <= 1'b0;
        flash_prog  <= 1'b0;
        flash_erase <= 1'b0;
      end else begin
        cnt_ff <= cnt_ff - 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      bus.cpu_stall <= 1'b0;
      bus.irq_hold  <= 1'b0;
    end else begin
      bus.cpu_stall <= fl_ok || (busy_ff && cnt_ff != 32'h0000_0000);
      bus.irq_hold  <= fl_ok || (busy_ff && cnt_ff != 32'h0000_0000);
    end
  end

  // RAM holds data only, no reset needed
  always_ff @(posedge clk_sys) begin
    if (bus.xm_wr && !wen_ff && !busy_ff) begin
      ram_mem[ram_idx] <= bus.xm_wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      xrdata_ff  <= 8'h00;
      xrvalid_ff <= 1'b0;
    end else begin
      xrvalid_ff <= bus.xm_rd && !busy_ff;
      if (bus.xm_rd && !busy_ff) begin
        xrdata_ff <= ram_mem[ram_idx];
      end
    end
  end
  assign bus.xm_rdata  = xrdata_ff;
  assign bus.xm_rvalid = xrvalid_ff;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rdata_ff <= 8'h00;
    end else if (bus.sfr_rd) begin
      case (bus.sfr_addr)
        PSC_ADDR:   rdata_ff <= {6'b00_0000, een_ff, wen_ff};
        SCALE_ADDR: rdata_ff <= {oneshot_ff, 7'h00};
        KEY_ADDR:   rdata_ff <= {6'b00_0000, key_ff};
        XPAGE_ADDR: rdata_ff <= {7'h00, page_sel_ff};
        default:    rdata_ff <= 8'h00;
      endcase
    end
  end
  assign bus.sfr_rdata = rdata_ff;

  // Full-cycle sense when one-shot is off; brief pulse modelled as one-cycle gate
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sense_ff <= 1'b0;
    end else begin
      sense_ff <= oneshot_ff ? (bus.code_rd && !sense_ff) : bus.code_rd;
    end
  end
  assign bus.sense_pulse = sense_ff;
endmodule : flash_write_erase_guard

// [verif/flash_guard_assertions.sv]
// Concurrent checks on the interface between core end and guard
`timescale 1ns/10ps
module flash_guard_assertions
  import flash_guard_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       arst_n,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_rdata,
  input wire logic       xm_wr,
  input wire logic       xm_rd,
  input wire logic       xm_rvalid,
  input wire logic       cpu_stall,
  input wire logic       irq_hold,
  input wire logic       flash_prog,
  input wire logic       flash_erase,
  input wire logic       code_rd,
  input wire logic       sense_pulse
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  a_irq_held_op:
    assert property (irq_hold == cpu_stall) else $error("irq hold differs from stall");
  a_psc_high_zero:
    assert property (sfr_rd && sfr_addr == PSC_ADDR |=> sfr_rdata[7:2] == 6'h00)
    else $error("control upper bits not zero");
  a_scale_low_zero:
    assert property (sfr_rd && sfr_addr == SCALE_ADDR |=> sfr_rdata[6:0] == 7'h00)
    else $error("scale reserved bits not zero");
  a_key_high_zero:
    assert property (sfr_rd && sfr_addr == KEY_ADDR |=> sfr_rdata[7:2] == 6'h00)
    else $error("key upper bits not zero");
  a_page_high_zero:
    assert property (sfr_rd && sfr_addr == XPAGE_ADDR |=> sfr_rdata[7:1] == 7'h00)
    else $error("page upper bits not zero");
  a_read_hits_ram:
    assert property (xm_rd |=> xm_rvalid) else $error("external read gave no data");
  a_stall_spans_op:
    assert property (cpu_stall == (flash_prog || flash_erase)) else $error("stall not op");
  a_one_op_kind:
    assert property (!(flash_prog && flash_erase)) else $error("program and erase together");
  a_op_from_write:
    assert property ($rose(flash_prog || flash_erase) |-> $past(xm_wr))
    else $error("flash op without write");
  a_sense_after_fetch:
    assert property (sense_pulse |-> $past(code_rd)) else $error("sense without code read");

  c_prog: cover property ($rose(flash_prog));
  c_erase: cover property ($rose(flash_erase));
  c_disabled: cover property (sfr_rd && sfr_addr == KEY_ADDR ##1 sfr_rdata[1:0] == 2'b11);
endmodule : flash_guard_assertions

// [verif/flash_write_erase_guard_test.sv]
// Self-checking bench joining the core end to the guard
`timescale 1ns/10ps
module flash_write_erase_guard_test
  import flash_guard_pkg::*;
;
  localparam logic [7:0] WT = 8'h05;
  localparam logic [7:0] ET = 8'h14;
  logic        clk_sys, arst_n, rsp_xm_valid, rsp_busy, flash_prog, flash_erase;
  logic [1:0]  rd_pend;
  logic        req_sfr_wr, req_sfr_rd, req_xm_wr, req_xm_rd, req_xm_short, req_code_rd;
  logic [7:0]  req_sfr_addr, req_sfr_wdata, req_xm_wdata, rsp_sfr_rdata, rsp_xm_rdata;
  logic [7:0]  flash_wdata;
  logic [15:0] req_xm_addr, flash_addr, lfsr;
  logic [7:0]  sq[$], xq[$];
  logic [31:0] fq[$], fseen;
  int          n_mismatch, n_checks, span;

  flash_guard_if bus_if ();
  flash_write_erase_guard #(.WRITE_TICKS(WT), .ERASE_TICKS(ET)) flash_write_erase_guard_inst (
    .clk_sys(clk_sys), .arst_n(arst_n), .bus(bus_if), .flash_prog(flash_prog),
    .flash_erase(flash_erase), .flash_addr(flash_addr), .flash_wdata(flash_wdata));
  flash_guard_core_end flash_guard_core_end_inst (
    .clk_sys(clk_sys), .arst_n(arst_n), .bus(bus_if), .req_sfr_wr(req_sfr_wr),
    .req_sfr_rd(req_sfr_rd), .req_sfr_addr(req_sfr_addr), .req_sfr_wdata(req_sfr_wdata),
    .req_xm_wr(req_xm_wr), .req_xm_rd(req_xm_rd), .req_xm_short(req_xm_short),
    .req_xm_addr(req_xm_addr), .req_xm_wdata(req_xm_wdata), .req_code_rd(req_code_rd),
    .rsp_sfr_rdata(rsp_sfr_rdata), .rsp_xm_rdata(rsp_xm_rdata),
    .rsp_xm_valid(rsp_xm_valid), .rsp_busy(rsp_busy));
  flash_guard_assertions flash_guard_assertions_inst (
    .clk_sys(clk_sys), .arst_n(arst_n), .sfr_rd(bus_if.sfr_rd), .sfr_addr(bus_if.sfr_addr),
    .sfr_rdata(bus_if.sfr_rdata), .xm_wr(bus_if.xm_wr), .xm_rd(bus_if.xm_rd),
    .xm_rvalid(bus_if.xm_rvalid), .cpu_stall(bus_if.cpu_stall), .irq_hold(bus_if.irq_hold),
    .flash_prog(flash_prog), .flash_erase(flash_erase), .code_rd(bus_if.code_rd),
    .sense_pulse(bus_if.sense_pulse));

  function automatic logic [15:0] step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : step

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test

  // Requests made during a stall are dropped by the core end, so wait it out
  task automatic idle();
    int i;
    i = 0;
    repeat (3) @(posedge clk_sys);
    while ((bus_if.cpu_stall !== 1'b0 || rsp_busy !== 1'b0) && i < 100) begin
      @(posedge clk_sys);
      i++;
    end
    if (i == 100) begin
      n_mismatch++;
      stop_test();
    end
  endtask : idle

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    req_sfr_wr    <= 1'b1;
    req_sfr_addr  <= a;
    req_sfr_wdata <= d;
    @(posedge clk_sys);
    req_sfr_wr    <= 1'b0;
    idle();
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    sq.push_back(e);
    @(posedge clk_sys);
    req_sfr_rd   <= 1'b1;
    req_sfr_addr <= a;
    @(posedge clk_sys);
    req_sfr_rd   <= 1'b0;
    idle();
  endtask : rd

  task automatic xm(input logic w, input logic s, input logic [15:0] a, input logic [7:0] d);
    if (!w) xq.push_back(d);
    @(posedge clk_sys);
    req_xm_wr    <= w;
    req_xm_rd    <= !w;
    req_xm_short <= s;
    req_xm_addr  <= a;
    req_xm_wdata <= d;
    @(posedge clk_sys);
    req_xm_wr    <= 1'b0;
    req_xm_rd    <= 1'b0;
    idle();
  endtask : xm

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) req_code_rd <= lfsr[3];

  // Results are judged mid-cycle, clear of the launching edge
  always @(negedge clk_sys) begin
    // Core copy lags the bus by one cycle; the bus value still stands then
    if (rd_pend[1]) begin
      check(rsp_sfr_rdata, sq[0]);
      check(bus_if.sfr_rdata, sq.pop_front());
    end
    rd_pend = {rd_pend[0], bus_if.sfr_rd};
    if (rsp_xm_valid === 1'b1) check(rsp_xm_rdata, xq.pop_front());
    if (flash_prog | flash_erase) begin
      span++;
      fseen = {span[7:0], flash_addr, flash_wdata};
    end else if (span != 0) begin
      check(fseen, fq.pop_front());
      span = 0;
    end
  end

  initial begin
    logic [15:0] a;
    {req_sfr_wr, req_sfr_rd, req_xm_wr, req_xm_rd, req_xm_short, req_code_rd} = 6'h00;
    {req_sfr_addr, req_sfr_wdata, req_xm_wdata, req_xm_addr} = 40'h0;
    {arst_n, rd_pend, span, n_mismatch, n_checks} = '0;
    lfsr = 16'hf9fc;
    repeat (5) @(posedge clk_sys);
    arst_n <= 1'b1;
    rd(PSC_ADDR, 8'h00);
    rd(SCALE_ADDR, 8'h80);
    rd(KEY_ADDR, 8'h00);
    rd(XPAGE_ADDR, 8'h00);
    wr(PSC_ADDR, 8'hfe);
    rd(PSC_ADDR, 8'h02);
    wr(SCALE_ADDR, 8'h00);
    rd(SCALE_ADDR, 8'h00);
    wr(SCALE_ADDR, 8'h80);
    wr(XPAGE_ADDR, 8'hff);
    rd(XPAGE_ADDR, 8'h01);
    // Erase bit alone must leave writes on the RAM
    for (int i = 0; i < 4; i++) begin
      lfsr = step(lfsr);
      a = lfsr | 16'h0100;
      lfsr = step(lfsr);
      xm(1'b1, 1'b0, a, lfsr[7:0]);
      xm(1'b0, 1'b0, a ^ {lfsr[14:8], 9'h000}, lfsr[7:0]);
      xm(1'b0, 1'b1, {lfsr[15:8], a[7:0]}, lfsr[7:0]);
    end
    wr(PSC_ADDR, 8'h00);
    xm(1'b1, 1'b0, 16'h0034, 8'h5a);
    // Erase the page before a byte is programmed into it
    wr(PSC_ADDR, 8'h03);
    wr(KEY_ADDR, KEY_FIRST);
    wr(KEY_ADDR, KEY_SECOND);
    fq.push_back({ET, 16'h1200, 8'hff});
    xm(1'b1, 1'b0, 16'h1234, 8'h77);
    rd(KEY_ADDR, 8'h00);
    wr(PSC_ADDR, 8'h01);
    wr(KEY_ADDR, KEY_FIRST);
    rd(KEY_ADDR, 8'h01);
    wr(KEY_ADDR, KEY_SECOND);
    rd(KEY_ADDR, 8'h02);
    fq.push_back({WT, 16'h1234, 8'h3c});
    xm(1'b1, 1'b0, 16'h1234, 8'h3c);
    xm(1'b0, 1'b0, 16'h0034, 8'h5a);
    rd(KEY_ADDR, 8'h00);
    xm(1'b1, 1'b0, 16'h0034, 8'h99);
    rd(KEY_ADDR, 8'h03);
    xm(1'b0, 1'b0, 16'h0034, 8'h5a);
    wr(KEY_ADDR, KEY_FIRST);
    rd(KEY_ADDR, 8'h03);
    @(posedge clk_sys);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    rd(KEY_ADDR, 8'h00);
    wr(KEY_ADDR, 8'h12);
    rd(KEY_ADDR, 8'h03);
    repeat (5) @(posedge clk_sys);
    check(sq.size() + xq.size() + fq.size(), 0);
    stop_test();
  end
endmodule : flash_write_erase_guard_test
